// *** src/art_pkg.sv ***
package art_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [5:0] ADDR_TIMER_CTRL   = 6'h00;
  localparam logic [5:0] ADDR_COUNT_LOW    = 6'h04;
  localparam logic [5:0] ADDR_COUNT_HIGH   = 6'h08;
  localparam logic [5:0] ADDR_RELOAD_LOW   = 6'h0C;
  localparam logic [5:0] ADDR_RELOAD_HIGH  = 6'h10;
  localparam logic [5:0] ADDR_IRQ_STATUS   = 6'h14;
  localparam logic [5:0] ADDR_IRQ_ENABLE   = 6'h18;
  localparam logic [5:0] ADDR_IRQ_CLEAR    = 6'h1C;
  localparam logic [5:0] ADDR_VECTOR_ACK   = 6'h20;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int BIT_PIN_GATE     = 7;
  localparam int BIT_COUNT_SRC    = 6;
  localparam int BIT_OVF_FLAG     = 5;
  localparam int BIT_RUN_CONTROL  = 4;
  localparam int BIT_IRQ_A_FLAG   = 3;
  localparam int BIT_IRQ_A_TRIG   = 2;
  localparam int BIT_IRQ_B_FLAG   = 1;
  localparam int BIT_IRQ_B_TRIG   = 0;

  // Status / enable / clear layout
  localparam int EVT_OVERFLOW = 0;
  localparam int EVT_IRQ_A    = 1;
  localparam int EVT_IRQ_B    = 2;
  localparam int EVT_COUNT    = 3;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0]  RST_TIMER_CTRL = 8'h00;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [2:0]  RST_EVENTS     = 3'h0;
  localparam int          OSC_PER_MACHINE = 12;
  localparam logic [3:0]  SAMPLE_SLOT    = 4'h6;
  localparam logic [3:0]  LAST_SLOT      = 4'(OSC_PER_MACHINE - 1);

endpackage : art_pkg

// *** src/art_timer_counter.sv ***
// Functional notes
// - Count pin sampled once per machine cycle slot
// - Tick at osc/12 or external 1-to-0 transitions
// - Source bit: 1 pin, 0 internal
// - Run control enables counting
// - High/low bytes form one 16-bit counter
// - Overflow reloads count from reload bytes
// - Reload registers unchanged by reload
// - Overflow sets flag, may interrupt
// - Trigger select edge or level per pin
// - Irq flag and trigger bit positions
//
// Implementation choices: the Avalon-MM slave port and the address map.
module art_timer_counter
  import art_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [5:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  input  wire logic        countInputPin,
  input  wire logic        extIrqAPin,
  input  wire logic        extIrqBPin,
  output logic             irq,
  output logic             timerIrqReq,
  output logic             extIrqAReq,
  output logic             extIrqBReq
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]  ctrl_ff;
  logic [15:0] count_ff;
  logic [7:0]  reloadLow_ff;
  logic [7:0]  reloadHigh_ff;
  logic [3:0]  slot_ff;
  logic        pinSample_ff;
  logic        pinPrev_ff;
  logic        irqAPrev_ff;
  logic        irqBPrev_ff;
  logic [2:0]  status_ff;
  logic [2:0]  enable_ff;
  logic        ack_ff;
  logic [31:0] readData_ff;

  logic        wrEn;
  logic        rdEn;
  logic        lane0;
  logic        machineTick;
  logic        sampleStrobe;
  logic        pinFall;
  logic        enabled;
  logic        tick;
  logic        overflow;
  logic        edgeA;
  logic        edgeB;
  logic        vectorAck;
  logic [15:0] nxt_count;

  // ****************************************************************
  // Avalon slave: one wait state on reads, writes take at once
  // ****************************************************************
  assign wrEn  = avsWrite;
  assign rdEn  = avsRead && ack_ff;
  assign lane0 = avsByteEnable[0];
  assign avsWaitRequest = avsRead && !ack_ff;
  assign avsReadData    = readData_ff;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= avsRead && !ack_ff;
    end
  end

  // Read data registered in the wait cycle so it stands at the accept edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      readData_ff <= 32'h0000_0000;
    end else if (avsRead && !ack_ff) begin
      unique case (avsAddress)
        6'(ADDR_TIMER_CTRL):  readData_ff <= {24'h00_0000, ctrl_ff};
        6'(ADDR_COUNT_LOW):   readData_ff <= {24'h00_0000, count_ff[7:0]};
        6'(ADDR_COUNT_HIGH):  readData_ff <= {24'h00_0000, count_ff[15:8]};
        6'(ADDR_RELOAD_LOW):  readData_ff <= {24'h00_0000, reloadLow_ff};
        ADDR_RELOAD_HIGH:     readData_ff <= {24'h00_0000, reloadHigh_ff};
        ADDR_IRQ_STATUS:      readData_ff <= {28'h000_0000, pinSample_ff, status_ff};
        ADDR_IRQ_ENABLE:      readData_ff <= {29'h0000_0000, enable_ff};
        default:              readData_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign vectorAck = wrEn && lane0 && (avsAddress == ADDR_VECTOR_ACK) && avsWriteData[0];

  // ****************************************************************
  // Machine cycle timing
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      slot_ff <= 4'h0;
    end else if (slot_ff == LAST_SLOT) begin
      slot_ff <= 4'h0;
    end else begin
      slot_ff <= slot_ff + 4'h1;
    end
  end

  assign machineTick  = (slot_ff == LAST_SLOT);
  assign sampleStrobe = (slot_ff == SAMPLE_SLOT);

  // Pin is synchronous by assumption; one sample per machine cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinSample_ff <= 1'b0;
      pinPrev_ff   <= 1'b0;
    end else if (sampleStrobe) begin
      pinSample_ff <= countInputPin;
      pinPrev_ff   <= pinSample_ff;
    end
  end

  // Counted one cycle after the second sample, so an edge spans two cycles
  assign pinFall = sampleStrobe && pinPrev_ff && !pinSample_ff;

  // ****************************************************************
  // Counter
  // ****************************************************************
  assign enabled = ctrl_ff[BIT_RUN_CONTROL] &&
                   (!ctrl_ff[BIT_PIN_GATE] || extIrqAPin);
  assign tick = enabled &&
                (ctrl_ff[BIT_COUNT_SRC] ? pinFall : machineTick);
  assign overflow = tick && (count_ff == 16'hFFFF);

  always_comb begin
    nxt_count = count_ff;
    if (tick) begin
      nxt_count = overflow ? {reloadHigh_ff, reloadLow_ff}
                           : count_ff + 16'h0001;
    end
    if (wrEn && lane0 && avsAddress == 6'(ADDR_COUNT_LOW)) begin
      nxt_count[7:0] = avsWriteData[7:0];
    end
    if (wrEn && lane0 && avsAddress == 6'(ADDR_COUNT_HIGH)) begin
      nxt_count[15:8] = avsWriteData[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      count_ff <= {RST_BYTE, RST_BYTE};
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Only software writes these; reload never touches them
  always_ff @(posedge mclk) begin
    if (srst) begin
      reloadLow_ff  <= RST_BYTE;
      reloadHigh_ff <= RST_BYTE;
    end else if (wrEn && lane0) begin
      if (avsAddress == 6'(ADDR_RELOAD_LOW)) begin
        reloadLow_ff <= avsWriteData[7:0];
      end
      if (avsAddress == ADDR_RELOAD_HIGH) begin
        reloadHigh_ff <= avsWriteData[7:0];
      end
    end
  end

  // ****************************************************************
  // External interrupt pins
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqAPrev_ff <= 1'b1;
      irqBPrev_ff <= 1'b1;
    end else begin
      irqAPrev_ff <= extIrqAPin;
      irqBPrev_ff <= extIrqBPin;
    end
  end

  // Active low inputs: falling edge in edge mode, low level otherwise
  assign edgeA = ctrl_ff[BIT_IRQ_A_TRIG] ? (irqAPrev_ff && !extIrqAPin)
                                         : !extIrqAPin;
  assign edgeB = ctrl_ff[BIT_IRQ_B_TRIG] ? (irqBPrev_ff && !extIrqBPin)
                                         : !extIrqBPin;

  // ****************************************************************
  // Control register; hardware sets win over software writes
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_ff <= RST_TIMER_CTRL;
    end else begin
      if (wrEn && lane0 && avsAddress == 6'(ADDR_TIMER_CTRL)) begin
        ctrl_ff <= avsWriteData[7:0];
      end
      if (vectorAck) begin
        ctrl_ff[BIT_OVF_FLAG] <= 1'b0;
      end
      if (overflow) begin
        ctrl_ff[BIT_OVF_FLAG] <= 1'b1;
      end
      if (edgeA) begin
        ctrl_ff[BIT_IRQ_A_FLAG] <= 1'b1;
      end else if (!ctrl_ff[BIT_IRQ_A_TRIG]) begin
        ctrl_ff[BIT_IRQ_A_FLAG] <= 1'b0;
      end
      if (edgeB) begin
        ctrl_ff[BIT_IRQ_B_FLAG] <= 1'b1;
      end else if (!ctrl_ff[BIT_IRQ_B_TRIG]) begin
        ctrl_ff[BIT_IRQ_B_FLAG] <= 1'b0;
      end
    end
  end

  assign timerIrqReq = ctrl_ff[BIT_OVF_FLAG];
  assign extIrqAReq  = ctrl_ff[BIT_IRQ_A_FLAG];
  assign extIrqBReq  = ctrl_ff[BIT_IRQ_B_FLAG];

  // ****************************************************************
  // Sticky status, enable, clear
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_ff <= RST_EVENTS;
      enable_ff <= RST_EVENTS;
    end else begin
      if (wrEn && lane0 && avsAddress == ADDR_IRQ_ENABLE) begin
        enable_ff <= avsWriteData[2:0];
      end
      status_ff <= (status_ff &
                    ~((wrEn && lane0 && avsAddress == ADDR_IRQ_CLEAR)
                      ? avsWriteData[2:0] : 3'h0))
                   | {edgeB && ctrl_ff[BIT_IRQ_B_TRIG],
                      edgeA && ctrl_ff[BIT_IRQ_A_TRIG], overflow};
    end
  end

  // Level output, registered so it never glitches on bus writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_ff & enable_ff);
    end
  end

endmodule : art_timer_counter

// *** tb/art_timer_counter_sva.sv ***
// ********
// Bus and timer checks
// ********
module art_timer_counter_sva
  import art_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [5:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0]  avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  input wire logic        irq,
  input wire logic        timerIrqReq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       runSh_ff;
  logic [2:0] enSh_ff;
  logic       wrLo;
  logic       ctrlWr;
  logic       ackWr;
  assign wrLo = avsWrite && avsByteEnable[0];
  assign ctrlWr = wrLo && avsAddress == 6'(ADDR_TIMER_CTRL);
  assign ackWr = wrLo && avsAddress == ADDR_VECTOR_ACK && avsWriteData[0];
  // Shadows come from bus writes only, since hardware never moves these bits
  always_ff @(posedge mclk) begin
    if (srst) runSh_ff <= 1'b0;
    else if (ctrlWr) runSh_ff <= avsWriteData[BIT_RUN_CONTROL];
  end
  always_ff @(posedge mclk) begin
    if (srst) enSh_ff <= 3'h0;
    else if (wrLo && avsAddress == ADDR_IRQ_ENABLE) enSh_ff <= avsWriteData[2:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_write_no_wait: assert property (avsWrite |-> !avsWaitRequest)
    else $error("write stalled");
  a_read_wait_first: assert property ($rose(avsRead) |-> avsWaitRequest)
    else $error("read answered in first cycle");
  a_read_ack_next: assert property (avsRead && avsWaitRequest |=> !avsWaitRequest)
    else $error("read answer late");
  a_unmapped_zero: assert property (avsRead && !avsWaitRequest &&
    avsAddress > ADDR_VECTOR_ACK |-> avsReadData == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (avsRead && !avsWaitRequest |-> avsReadData[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_clear: assert property ($past(srst) |-> !timerIrqReq && !irq)
    else $error("flag or irq set after reset");
  a_ack_clears: assert property (ackWr && !runSh_ff |=> !timerIrqReq)
    else $error("vector ack left flag set");
  a_stop_no_ovf: assert property ($rose(timerIrqReq) |-> $past(runSh_ff) || $past(ctrlWr))
    else $error("overflow while stopped");
  a_irq_masked: assert property (irq |-> $past(enSh_ff) != 3'h0)
    else $error("irq with all sources masked");
  c_run: cover property (ctrlWr && avsWriteData[BIT_RUN_CONTROL]);
  c_ovf: cover property ($rose(timerIrqReq));
  c_irq: cover property ($rose(irq));
endmodule : art_timer_counter_sva
bind art_timer_counter art_timer_counter_sva u_sva (
  .mclk(mclk), .srst(srst), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .irq(irq),
  .timerIrqReq(timerIrqReq)
);

// *** tb/art_timer_counter_test.sv ***
module art_timer_counter_test
  import art_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Stimulus and checks
  // ********
  logic        mclk = 1'b0, srst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
  logic [5:0]  avsAddress = 6'h00;
  logic [31:0] avsWriteData = 32'h0000_0000, avsReadData;
  logic [3:0]  avsByteEnable = 4'h1;
  logic        countInputPin = 1'b0, extIrqAPin = 1'b1, extIrqBPin = 1'b1;
  logic        avsWaitRequest, irq, timerIrqReq, extIrqAReq, extIrqBReq;
  int          errorCnt = 0, nCompared = 0, k, tb;
  logic [31:0] rnd = 32'h707f_a69a;
  logic [7:0]  rdv;
  logic [15:0] st, rl, cnt;
  logic [5:0]  regs[9] = '{ADDR_TIMER_CTRL, ADDR_COUNT_LOW, ADDR_COUNT_HIGH,
    ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH, ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR, 6'h3c};
  art_timer_counter DUT (.mclk(mclk), .srst(srst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .countInputPin(countInputPin),
    .extIrqAPin(extIrqAPin), .extIrqBPin(extIrqBPin), .irq(irq),
    .timerIrqReq(timerIrqReq), .extIrqAReq(extIrqAReq), .extIrqBReq(extIrqBReq));
  always #2 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] advance(input logic [15:0] c, r, input int n);
    repeat (n) c = (c == 16'hffff) ? r : c + 16'h0001;
    return c;
  endfunction : advance
  task automatic chk(input string nm, input logic [15:0] s, e);
    nCompared++;
    if (s !== e) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Request held until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    avsAddress <= a;
    avsWriteData <= {24'h0, d};
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge mclk); while (avsWaitRequest);
    rdv = avsReadData[7:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : bus
  task automatic wr16(input logic [5:0] lo, hi, input logic [15:0] v);
    bus(1'b1, lo, v[7:0]);
    bus(1'b1, hi, v[15:8]);
  endtask : wr16
  task automatic rd16(input logic [5:0] lo, hi);
    bus(1'b0, lo, 8'h00);
    cnt[7:0] = rdv;
    bus(1'b0, hi, 8'h00);
    cnt[15:8] = rdv;
  endtask : rd16
  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 8'h00);
      chk("reset value", {8'h00, rdv}, 16'h0000);
    end
    $display("test reset done");
    rnd = lfsr(rnd);
    rl = rnd[15:0];
    st = 16'hfff8 + {13'h0, rnd[18:16]};
    wr16(ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH, rl);
    wr16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH, st);
    bus(1'b1, ADDR_TIMER_CTRL, 8'h10);
    // Run stays set for 120 cycles, exactly ten machine cycles
    repeat (118) @(posedge mclk);
    bus(1'b1, ADDR_TIMER_CTRL, 8'h20);
    rd16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH);
    chk("count", cnt, advance(st, rl, 10));
    rd16(ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH);
    chk("reload", cnt, rl);
    repeat (50) @(posedge mclk);
    rd16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH);
    chk("stopped count", cnt, advance(st, rl, 10));
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk("status", {8'h00, rdv}, 16'h0001);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    bus(1'b1, ADDR_IRQ_ENABLE, 8'h01);
    repeat (2) @(negedge mclk);
    chk("irq", {15'h0, irq}, 16'h0001);
    bus(1'b1, ADDR_VECTOR_ACK, 8'h01);
    bus(1'b0, ADDR_TIMER_CTRL, 8'h00);
    chk("ack flag", {8'h00, rdv}, 16'h0000);
    chk("ack req", {15'h0, timerIrqReq}, 16'h0000);
    bus(1'b1, ADDR_IRQ_CLEAR, 8'h01);
    repeat (2) @(negedge mclk);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
    $display("test timer done");
    rnd = lfsr(rnd);
    k = 1 + int'(rnd[1:0]);
    wr16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH, 16'hfffe);
    bus(1'b1, ADDR_TIMER_CTRL, 8'h50);
    repeat (k) begin
      countInputPin <= 1'b1;
      repeat (24) @(posedge mclk);
      countInputPin <= 1'b0;
      repeat (24) @(posedge mclk);
    end
    bus(1'b0, ADDR_TIMER_CTRL, 8'h00);
    chk("pin ovf", {8'h00, rdv}, (k > 1) ? 16'h0070 : 16'h0050);
    bus(1'b1, ADDR_TIMER_CTRL, 8'h00);
    rd16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH);
    chk("pin count", cnt, advance(16'hfffe, rl, k));
    $display("test counter done");
    extIrqAPin <= 1'b0;
    wr16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH, 16'h0100);
    bus(1'b1, ADDR_TIMER_CTRL, 8'h90);
    repeat (60) @(posedge mclk);
    bus(1'b1, ADDR_TIMER_CTRL, 8'h00);
    rd16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH);
    chk("gated count", cnt, 16'h0100);
    extIrqAPin <= 1'b1;
    bus(1'b1, ADDR_TIMER_CTRL, 8'h90);
    repeat (118) @(posedge mclk);
    bus(1'b1, ADDR_TIMER_CTRL, 8'h00);
    rd16(ADDR_COUNT_LOW, ADDR_COUNT_HIGH);
    chk("open count", cnt, 16'h010a);
    $display("test gate done");
    for (int i = 0; i < 2; i++) begin
      tb = i ? 0 : 2;
      bus(1'b1, ADDR_TIMER_CTRL, 8'(1 << tb));
      if (i) extIrqBPin <= 1'b0;
      else extIrqAPin <= 1'b0;
      repeat (4) @(negedge mclk);
      chk("edge req", {15'h0, i ? extIrqBReq : extIrqAReq}, 16'h0001);
      bus(1'b0, ADDR_TIMER_CTRL, 8'h00);
      chk("edge flag", {8'h00, rdv}, 16'(3 << tb));
      bus(1'b1, ADDR_TIMER_CTRL, 8'h00);
      bus(1'b0, ADDR_TIMER_CTRL, 8'h00);
      chk("level low", {8'h00, rdv}, 16'(2 << tb));
      if (i) extIrqBPin <= 1'b1;
      else extIrqAPin <= 1'b1;
      bus(1'b0, ADDR_TIMER_CTRL, 8'h00);
      chk("level high", {8'h00, rdv}, 16'h0000);
    end
    $display("test external done");
    conclude();
  end
endmodule : art_timer_counter_test
